// ---- sphi_clock_settle.sv ----
`timescale 1ns/1ps
`default_nettype none
// Counts the settling time after gated clocks restart and pulses once at the end
module sphi_clock_settle #(
  parameter int unsigned CYCLES = sphi_pkg::CLK_SETTLE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  output logic done_out
);
  import sphi_pkg::*;
  logic [SETTLE_W-1:0] count;
  logic running;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= '0;
      running <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count <= SETTLE_W'(CYCLES - 1);
        running <= 1'b1;
      end else if (running) begin
        if (count == '0) begin
          running <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- sphi_pkg.sv ----
package sphi_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h310;
  localparam logic [11:0] IRQ_ENABLE_OFFSET = 12'h314;
  localparam logic [11:0] PWR_DOWN_OFFSET = 12'h354;
  localparam logic [11:0] SUSPEND_CTRL_OFFSET = 12'h358;
  localparam int unsigned PD_CLOCK_KEEP_BIT = 0;
  localparam int unsigned PD_PORT1_OC_BIT = 1;
  localparam int unsigned PD_PORT2_OC_BIT = 2;
  localparam int unsigned PD_PORT3_OC_BIT = 3;
  localparam int unsigned PD_REG_LOWPWR_BIT = 4;
  localparam logic [4:0] PD_RESET = 5'h00;
  localparam logic [4:0] PD_MASK = 5'h1f;
  localparam int unsigned ST_CLOCK_STABLE_BIT = 6;
  localparam int unsigned ST_ASYNC_DONE_BIT = 8;
  localparam int unsigned ST_ISO_DONE_BIT = 9;
  localparam int unsigned ST_ROLE_SWITCH_BIT = 10;
  localparam logic [31:0] ST_MASK = 32'h0000_0740;
  localparam logic [31:0] ST_RESET = 32'h0000_0000;
  localparam int unsigned CLK_RATE_MHZ = 250;
  localparam int unsigned CLK_SETTLE_NS = 200;
  localparam int unsigned CLK_SETTLE_CYC = (CLK_SETTLE_NS * CLK_RATE_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_W = 8;
  typedef enum logic [1:0] {
    SPHI_RUN = 2'b00,
    SPHI_SUSP = 2'b01,
    SPHI_SETTLE = 2'b10
  } sphi_clk_state_t;
endpackage

// ---- sphi_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Bit 4 puts regulators low-power in suspend
// R2: Bit 3 disables port 3 overcurrent in suspend
// R3: Bit 2 disables port 2 overcurrent in suspend
// R4: Bit 1 disables port 1 overcurrent in suspend
// R5: Bit 0 clear: only slow clock in suspend
// R6: Bit 0 set: all clocks keep running
// R7: Clock-stable event after stopped clocks restart
// R8: Software rewrites power-down value in 16-bit mode
// R9: Status flags clear only on written one
// R10: Global enable never gates flag latching
// R11: Software clears flags before enabling events
// R12: Status bits 10,9,8 at 0x310, reset zero
// R13: Interrupt when flag and enable both set
// R14: Status bit 6 latches clock-stable event
// R15: Power settings act only during suspend
module sphi_regs (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [sphi_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sphi_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [sphi_pkg::DATA_W-1:0] rdata_out,
  input wire logic suspend_in,
  input wire logic global_interrupt_enable_in,
  input wire logic role_switch_event_in,
  input wire logic iso_done_event_in,
  input wire logic asynchronous_done_event_in,
  output logic suspend_regulator_lowpower_out,
  output logic port3_overcurrent_enable_out,
  output logic port2_overcurrent_enable_out,
  output logic port1_overcurrent_enable_out,
  output logic fast_clock_enable_out,
  output logic irq_out
);
  import sphi_pkg::*;

  logic [4:0] pwr_down;
  logic [31:0] status;
  logic [31:0] enable;
  logic susp_mode;
  sphi_clk_state_t clk_state;
  logic settle_start;
  logic clock_stable_event;
  logic [31:0] events;
  logic [31:0] clr;
  logic [31:0] next_status;
  logic wr_pd;
  logic wr_st;
  logic wr_en;
  logic wr_sc;

  assign wr_pd = wr_in && (addr_in == PWR_DOWN_OFFSET);
  assign wr_st = wr_in && (addr_in == IRQ_STATUS_OFFSET);
  assign wr_en = wr_in && (addr_in == IRQ_ENABLE_OFFSET);
  assign wr_sc = wr_in && (addr_in == SUSPEND_CTRL_OFFSET);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr_down <= PD_RESET;
    end else if (wr_pd) begin
      pwr_down <= wdata_in[4:0] & PD_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      enable <= ST_RESET;
    end else if (wr_en) begin
      enable <= wdata_in & ST_MASK;
    end
  end

  // Software-commanded suspend only; the pin from the power manager is ORed in where it is used
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      susp_mode <= 1'b0;
    end else if (wr_sc) begin
      susp_mode <= wdata_in[0];
    end
  end

  // Clock gating: stops fast clocks only when suspended with keep bit clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_state <= SPHI_RUN;
      fast_clock_enable_out <= 1'b1;
    end else begin
      case (clk_state)
        SPHI_RUN: begin
          if ((suspend_in || susp_mode) && !pwr_down[PD_CLOCK_KEEP_BIT]) begin // [R5] [R15]
            clk_state <= SPHI_SUSP;
            fast_clock_enable_out <= 1'b0;
          end else begin
            fast_clock_enable_out <= 1'b1; // [R6]
          end
        end
        SPHI_SUSP: begin
          // Keep bit set mid-suspend also restarts clocks
          if (!(suspend_in || susp_mode) || pwr_down[PD_CLOCK_KEEP_BIT]) begin // [R6]
            clk_state <= SPHI_SETTLE;
            fast_clock_enable_out <= 1'b1;
          end
        end
        SPHI_SETTLE: begin
          if (clock_stable_event) begin
            clk_state <= SPHI_RUN;
          end
        end
        default: begin
          clk_state <= SPHI_RUN;
          fast_clock_enable_out <= 1'b1;
        end
      endcase
    end
  end

  assign settle_start = (clk_state == SPHI_SUSP) &&
                        (!(suspend_in || susp_mode) || pwr_down[PD_CLOCK_KEEP_BIT]);

  sphi_clock_settle #(
    .CYCLES(CLK_SETTLE_CYC)
  ) u_settle (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .start_in(settle_start),
    .done_out(clock_stable_event) // [R7]
  );

  // Suspend-only power controls; normal operation keeps everything on
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      suspend_regulator_lowpower_out <= 1'b0;
      port3_overcurrent_enable_out <= 1'b1;
      port2_overcurrent_enable_out <= 1'b1;
      port1_overcurrent_enable_out <= 1'b1;
    end else begin
      suspend_regulator_lowpower_out <= (suspend_in || susp_mode) && pwr_down[PD_REG_LOWPWR_BIT]; // [R1] [R15]
      port3_overcurrent_enable_out <= !((suspend_in || susp_mode) && pwr_down[PD_PORT3_OC_BIT]); // [R2]
      port2_overcurrent_enable_out <= !((suspend_in || susp_mode) && pwr_down[PD_PORT2_OC_BIT]); // [R3]
      port1_overcurrent_enable_out <= !((suspend_in || susp_mode) && pwr_down[PD_PORT1_OC_BIT]); // [R4]
    end
  end

  always_comb begin
    events = '0;
    events[ST_CLOCK_STABLE_BIT] = clock_stable_event; // [R14]
    events[ST_ASYNC_DONE_BIT] = asynchronous_done_event_in; // [R12]
    events[ST_ISO_DONE_BIT] = iso_done_event_in;
    events[ST_ROLE_SWITCH_BIT] = role_switch_event_in;
    clr = wr_st ? wdata_in : '0;
    // Set wins over a same-cycle clear; global enable is deliberately unused here
    next_status = ((status & ~clr) | events) & ST_MASK; // [R9] [R10]
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status <= ST_RESET; // [R12]
    end else begin
      status <= next_status;
    end
  end

  // Output flopped, so it trails the status by one cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & enable); // [R13]
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        IRQ_STATUS_OFFSET: rdata_out <= status;
        IRQ_ENABLE_OFFSET: rdata_out <= enable;
        PWR_DOWN_OFFSET: rdata_out <= {27'h0, pwr_down}; // [R8]
        SUSPEND_CTRL_OFFSET: rdata_out <= {30'h0, (clk_state == SPHI_SUSP), susp_mode};
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  logic unused_gie;
  assign unused_gie = global_interrupt_enable_in;

  AST_W1C_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_st && wdata_in[ST_ASYNC_DONE_BIT] && !asynchronous_done_event_in) |=> !status[ST_ASYNC_DONE_BIT]) // [R9]
    else $error("status flag not cleared by write one");
  AST_W0_KEEPS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (status[ST_ISO_DONE_BIT] && !(wr_st && wdata_in[ST_ISO_DONE_BIT])) |=> status[ST_ISO_DONE_BIT]) // [R9]
    else $error("status flag lost without write one");
  AST_SET_WINS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    role_switch_event_in |=> status[ST_ROLE_SWITCH_BIT]) // [R10]
    else $error("event not latched");
  AST_IRQ_LEVEL: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    |(status & enable) |=> irq_out) // [R13]
    else $error("interrupt not raised");
  AST_IRQ_LOW: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(|(status & enable)) |=> !irq_out) // [R13]
    else $error("interrupt raised without cause");
  AST_REG_NORMAL: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!suspend_in && !susp_mode) |=> (!suspend_regulator_lowpower_out && port1_overcurrent_enable_out)) // [R15]
    else $error("suspend setting acting in normal mode");
  AST_REG_LOWPWR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (suspend_in && pwr_down[PD_REG_LOWPWR_BIT]) |=> suspend_regulator_lowpower_out) // [R1]
    else $error("regulator not low power in suspend");
  AST_OC3_OFF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (suspend_in && pwr_down[PD_PORT3_OC_BIT]) |=> !port3_overcurrent_enable_out) // [R2]
    else $error("port 3 detection not off");
  AST_OC2_OFF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (suspend_in && pwr_down[PD_PORT2_OC_BIT]) |=> !port2_overcurrent_enable_out) // [R3]
    else $error("port 2 detection not off");
  AST_OC1_OFF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (suspend_in && pwr_down[PD_PORT1_OC_BIT]) |=> !port1_overcurrent_enable_out) // [R4]
    else $error("port 1 detection not off");
  AST_CLK_STOP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_state == SPHI_RUN && suspend_in && !pwr_down[PD_CLOCK_KEEP_BIT]) |=> !fast_clock_enable_out) // [R5]
    else $error("clocks not stopped in suspend");
  AST_CLK_KEEP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_state == SPHI_RUN && pwr_down[PD_CLOCK_KEEP_BIT]) |=> fast_clock_enable_out) // [R6]
    else $error("clocks gated despite keep bit");
  AST_STABLE_EVT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    settle_start |-> ##[1:60] status[ST_CLOCK_STABLE_BIT]) // [R7] [R14]
    else $error("clock-stable flag not raised");
  AST_LOWPWR_OFF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !pwr_down[PD_REG_LOWPWR_BIT] |=> !suspend_regulator_lowpower_out) // [R1]
    else $error("regulator low power with bit clear");
  AST_LOWPWR_SOFT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (susp_mode && pwr_down[PD_REG_LOWPWR_BIT]) |=> suspend_regulator_lowpower_out) // [R1]
    else $error("regulator not low power in soft suspend");
  AST_OC3_ON: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!(suspend_in || susp_mode) || !pwr_down[PD_PORT3_OC_BIT]) |=> port3_overcurrent_enable_out) // [R2]
    else $error("port 3 detection off unexpectedly");
  AST_OC2_ON: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!(suspend_in || susp_mode) || !pwr_down[PD_PORT2_OC_BIT]) |=> port2_overcurrent_enable_out) // [R3]
    else $error("port 2 detection off unexpectedly");
  AST_OC1_ON: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!(suspend_in || susp_mode) || !pwr_down[PD_PORT1_OC_BIT]) |=> port1_overcurrent_enable_out) // [R4]
    else $error("port 1 detection off unexpectedly");
  AST_OC3_SOFT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (susp_mode && pwr_down[PD_PORT3_OC_BIT]) |=> !port3_overcurrent_enable_out) // [R2]
    else $error("port 3 detection on in soft suspend");
  AST_OC2_SOFT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (susp_mode && pwr_down[PD_PORT2_OC_BIT]) |=> !port2_overcurrent_enable_out) // [R3]
    else $error("port 2 detection on in soft suspend");
  AST_OC1_SOFT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (susp_mode && pwr_down[PD_PORT1_OC_BIT]) |=> !port1_overcurrent_enable_out) // [R4]
    else $error("port 1 detection on in soft suspend");
  AST_NORMAL_OC: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!suspend_in && !susp_mode) |=> (port3_overcurrent_enable_out && port2_overcurrent_enable_out)) // [R15]
    else $error("detection off in normal mode");
  AST_NORMAL_CLK: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_state == SPHI_RUN && !suspend_in && !susp_mode) |=> fast_clock_enable_out) // [R15]
    else $error("clocks gated in normal mode");
  AST_CLK_STOP_SOFT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_state == SPHI_RUN && susp_mode && !pwr_down[PD_CLOCK_KEEP_BIT]) |=> !fast_clock_enable_out) // [R5]
    else $error("clocks not stopped in soft suspend");
  AST_SUSP_GATED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_state == SPHI_SUSP) |-> !fast_clock_enable_out) // [R5]
    else $error("fast clocks running while stopped");
  AST_SETTLE_RUNNING: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_state == SPHI_SETTLE) |-> fast_clock_enable_out) // [R7]
    else $error("fast clocks off while settling");
  AST_KEEP_WAKES: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_state == SPHI_SUSP && pwr_down[PD_CLOCK_KEEP_BIT]) |=> (clk_state == SPHI_SETTLE && fast_clock_enable_out)) // [R6]
    else $error("keep bit did not restart clocks");
  AST_RESUME: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_state == SPHI_SUSP && !suspend_in && !susp_mode) |=> fast_clock_enable_out) // [R7]
    else $error("clocks not restarted on resume");
  AST_STABLE_ONCE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clock_stable_event |=> !clock_stable_event) // [R7]
    else $error("clock-stable event longer than one cycle");
  // Settle count of 50 plus the start edge
  AST_STABLE_DELAY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    settle_start |-> ##51 clock_stable_event) // [R7]
    else $error("clock-stable event at wrong time");
  AST_STABLE_IN_SETTLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clock_stable_event |-> (clk_state == SPHI_SETTLE)) // [R7]
    else $error("clock-stable event outside settling");
  AST_SETTLE_LEAVES: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clock_stable_event |=> (clk_state == SPHI_RUN)) // [R7]
    else $error("settling not finished after event");
  AST_STABLE_FLAG: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clock_stable_event |=> status[ST_CLOCK_STABLE_BIT]) // [R14]
    else $error("clock-stable flag not latched");
  AST_W1C_ISO: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_st && wdata_in[ST_ISO_DONE_BIT] && !iso_done_event_in) |=> !status[ST_ISO_DONE_BIT]) // [R9]
    else $error("iso flag not cleared by write one");
  AST_W1C_ROLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_st && wdata_in[ST_ROLE_SWITCH_BIT] && !role_switch_event_in) |=> !status[ST_ROLE_SWITCH_BIT]) // [R9]
    else $error("role flag not cleared by write one");
  AST_W1C_CLOCK: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_st && wdata_in[ST_CLOCK_STABLE_BIT] && !clock_stable_event) |=> !status[ST_CLOCK_STABLE_BIT]) // [R9]
    else $error("clock flag not cleared by write one");
  AST_W0_KEEPS_ASYNC: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (status[ST_ASYNC_DONE_BIT] && !(wr_st && wdata_in[ST_ASYNC_DONE_BIT])) |=> status[ST_ASYNC_DONE_BIT]) // [R9]
    else $error("async flag lost without write one");
  AST_W0_KEEPS_ROLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (status[ST_ROLE_SWITCH_BIT] && !(wr_st && wdata_in[ST_ROLE_SWITCH_BIT])) |=> status[ST_ROLE_SWITCH_BIT]) // [R9]
    else $error("role flag lost without write one");
  AST_W0_KEEPS_CLOCK: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (status[ST_CLOCK_STABLE_BIT] && !(wr_st && wdata_in[ST_CLOCK_STABLE_BIT])) |=> status[ST_CLOCK_STABLE_BIT]) // [R9]
    else $error("clock flag lost without write one");
  AST_ISO_SET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    iso_done_event_in |=> status[ST_ISO_DONE_BIT]) // [R10]
    else $error("iso event not latched");
  AST_ASYNC_SET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    asynchronous_done_event_in |=> status[ST_ASYNC_DONE_BIT]) // [R10]
    else $error("async event not latched");
  AST_NO_SPURIOUS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!status[ST_ASYNC_DONE_BIT] && !asynchronous_done_event_in) |=> !status[ST_ASYNC_DONE_BIT]) // [R12]
    else $error("async flag set without event");
  AST_RESERVED_ZERO: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (status & ~ST_MASK) == 32'h0000_0000) // [R12]
    else $error("reserved status bit set");
  AST_ENABLE_RESERVED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (enable & ~ST_MASK) == 32'h0000_0000) // [R13]
    else $error("reserved enable bit set");
  AST_IRQ_MASKED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (enable == 32'h0000_0000) |=> !irq_out) // [R13]
    else $error("interrupt raised with all masked");
  AST_STATUS_READ: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rd_in && addr_in == IRQ_STATUS_OFFSET) |=> (rdata_out == $past(status))) // [R12]
    else $error("status read data wrong");
  AST_PD_READBACK: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rd_in && addr_in == PWR_DOWN_OFFSET) |=> (rdata_out == {27'h0, $past(pwr_down)})) // [R8]
    else $error("power-down read data wrong");
  COV_SUSP_RESUME: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_state == SPHI_SUSP ##[1:100] clock_stable_event);
  COV_CLEAR: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    status[ST_ASYNC_DONE_BIT] ##1 wr_st ##1 !status[ST_ASYNC_DONE_BIT]);
  COV_IRQ: cover property (@(posedge clk_in) disable iff (!rst_b_in) irq_out);
  COV_SOFT_SUSPEND: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    susp_mode && !fast_clock_enable_out);
  COV_SET_ON_CLEAR: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_st && wdata_in[ST_ASYNC_DONE_BIT] && asynchronous_done_event_in) ##1 status[ST_ASYNC_DONE_BIT]);
endmodule
`default_nettype wire

// ---- suspend_power_and_host_irq_status_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module suspend_power_and_host_irq_status_test;
  import sphi_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic suspend_in = 1'b0;
  logic gie = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [31:0] rdata_out;
  logic lp, oc3, oc2, oc1, fce, irq;
  logic [31:0] d;
  int failures = 0;
  int checks = 0;
  // Row: power-down value, suspend level, then {lowpower, oc3, oc2, oc1, fast clock} expected
  logic [10:0] rows [9] = '{
    {5'h00, 1'b0, 5'h0f}, {5'h1f, 1'b0, 5'h0f}, {5'h1f, 1'b1, 5'h11},
    {5'h10, 1'b1, 5'h1e}, {5'h08, 1'b1, 5'h06}, {5'h04, 1'b1, 5'h0a},
    {5'h02, 1'b1, 5'h0c}, {5'h01, 1'b1, 5'h0f}, {5'h00, 1'b1, 5'h0e}};

  sphi_regs dut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .suspend_in(suspend_in),
    .global_interrupt_enable_in(gie),
    .role_switch_event_in(ev[2]),
    .iso_done_event_in(ev[1]),
    .asynchronous_done_event_in(ev[0]),
    .suspend_regulator_lowpower_out(lp),
    .port3_overcurrent_enable_out(oc3),
    .port2_overcurrent_enable_out(oc2),
    .port1_overcurrent_enable_out(oc1),
    .fast_clock_enable_out(fce),
    .irq_out(irq)
  );

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge clk_in);
    ev <= m;
    @(posedge clk_in);
    ev <= 3'h0;
  endtask

  task automatic end_of_test;
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    #1 chk({26'h0, lp, oc3, oc2, oc1, fce, irq}, 32'h1e);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, ST_RESET);
    rd(PWR_DOWN_OFFSET, d);
    chk(d, {27'h0, PD_RESET});
    for (int i = 0; i < 9; i++) begin
      wr(PWR_DOWN_OFFSET, {27'h0, rows[i][10:6]});
      suspend_in <= rows[i][5];
      repeat (3) @(posedge clk_in);
      #1 chk({27'h0, lp, oc3, oc2, oc1, fce}, {27'h0, rows[i][4:0]});
      rd(PWR_DOWN_OFFSET, d);
      chk(d, {27'h0, rows[i][10:6]});
      @(posedge clk_in);
      suspend_in <= 1'b0;
      repeat (60) @(posedge clk_in);
    end
    wr(IRQ_STATUS_OFFSET, 32'hffff_ffff);
    // Gated clocks restart: flag must wait out the settle time, then latch
    @(posedge clk_in);
    suspend_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    suspend_in <= 1'b0;
    repeat (CLK_SETTLE_CYC - 6) @(posedge clk_in);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 32'h0);
    repeat (8) @(posedge clk_in);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 32'h40);
    wr(IRQ_STATUS_OFFSET, 32'h40);
    wr(IRQ_ENABLE_OFFSET, 32'h0);
    // Global enable high must not change what latches
    gie <= 1'b1;
    pulse(3'h7);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 32'h700);
    chk({31'h0, irq}, 32'h0);
    wr(IRQ_ENABLE_OFFSET, ST_MASK);
    repeat (2) @(posedge clk_in);
    #1 chk({31'h0, irq}, 32'h1);
    wr(IRQ_STATUS_OFFSET, 32'h0);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 32'h700);
    wr(IRQ_STATUS_OFFSET, 32'h100);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 32'h600);
    wr(IRQ_ENABLE_OFFSET, 32'h100);
    repeat (2) @(posedge clk_in);
    #1 chk({31'h0, irq}, 32'h0);
    wr(IRQ_STATUS_OFFSET, 32'hffff_ffff);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 32'h0);
    rd(12'h100, d);
    chk(d, 32'h0);
    // An event landing on the clearing write must not be lost
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= IRQ_STATUS_OFFSET;
    wdata_in <= 32'h100;
    ev <= 3'h1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    ev <= 3'h0;
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 32'h100);
    // Software suspend request acts like the suspend pin
    wr(PWR_DOWN_OFFSET, 32'h10);
    wr(SUSPEND_CTRL_OFFSET, 32'h1);
    rd(SUSPEND_CTRL_OFFSET, d);
    chk(d, 32'h3);
    chk({27'h0, lp, oc3, oc2, oc1, fce}, 32'h1e);
    wr(SUSPEND_CTRL_OFFSET, 32'h0);
    repeat (60) @(posedge clk_in);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, 32'h140);
    wr(PWR_DOWN_OFFSET, 32'h1f);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(PWR_DOWN_OFFSET, d);
    chk(d, 32'h0);
    rd(IRQ_STATUS_OFFSET, d);
    chk(d, ST_RESET);
    end_of_test();
  end
endmodule
`default_nettype wire
